// File: pmrc_pkg.sv
// Purpose: Shared constants for the power-mode and reset controller.
// Assumes: 100 MHz system clock, 8-bit special register port.
// Notes: All offsets, bit positions, the power control reset value and cycle counts live here.
package pmrc_pkg;

  // Clock rate in kHz, used to turn times into cycle counts.
  localparam int unsigned CLK_KHZ = 100000;

  // Register addresses on the special register port.
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] RST_SRC_ADDR = 8'hEF;

  // Power control field positions and reset value.
  localparam int unsigned IDLE_BIT = 0;
  localparam int unsigned STOP_BIT = 1;
  localparam int unsigned FLAGS_LSB = 2;
  localparam int unsigned FLAGS_MSB = 6;
  localparam int unsigned BAUD_BIT = 7;
  localparam logic [7:0] PWR_CTRL_RST = 8'h00;

  // Reset source field positions.
  localparam int unsigned PIN_FLAG_BIT = 0;
  localparam int unsigned POR_FLAG_BIT = 1;
  localparam int unsigned MCD_FLAG_BIT = 2;
  localparam int unsigned WDT_FLAG_BIT = 3;

  // Entry point fetched after every reset.
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Supply monitor timeout in ms and missing clock timeout in us.
  localparam int unsigned MON_TIMEOUT_MS = 100;
  localparam int unsigned MON_TIMEOUT_CYC = MON_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned MCD_TIMEOUT_US = 100;
  localparam int unsigned MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * CLK_KHZ / 1000;

  // Power states, one-hot.
  typedef enum logic [3:0] {
    PMRC_RESET = 4'h1,
    PMRC_RUN = 4'h2,
    PMRC_IDLE = 4'h4,
    PMRC_STOP = 4'h8
  } pmrc_state_e;

endpackage

// File: pmrc_timer.sv
// Purpose: Counts a fixed number of enabled cycles and flags completion.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Restart reloads the count; done stays high until the next restart.
`timescale 1ns/100ps
module pmrc_timer #(
  parameter int unsigned COUNT = 16 // Cycles to count.
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic restart, // Reload and start counting.
  input wire logic run, // Count enable.
  output logic done // Count reached.
);

  localparam int unsigned W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  logic [W-1:0] cnt_q;

  // Counter holds at the last value so done is a level.
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (run && !done) begin
      if (cnt_q == LAST) begin
        done <= 1'b1;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

endmodule

// File: pmrc_ctrl.sv
// Purpose: Power-mode and reset controller: idle, stop, power-on and power-fail reset.
// Assumes: CPU reaches registers through an 8-bit special register port on clk.
// Notes: Supply monitor, reset pin and wake inputs are asynchronous and synchronised.
//
// Notes on behaviour
// R1: Setting idle bit halts only the CPU clock after the write completes.
// R2: Idle keeps all register and memory contents unchanged.
// R3: Enabled interrupt or reset ends idle; interrupt clears the idle bit.
// R4: After interrupt wake, return resumes at instruction after the idle write.
// R5: Reset ending idle runs the normal reset sequence from address 0x0000.
// R6: Software should follow the idle write with a multi-byte instruction.
// R7: Enabled watchdog eventually resets the device out of idle.
// R8: Setting stop bit halts CPU and oscillator, stopping digital peripherals.
// R9: Only a reset ends stop; execution restarts from address 0x0000.
// R10: Enabled missing clock detector resets out of stop after 100 us.
// R11: Idle and stop bits always read as zero.
// R12: Baud doubler set doubles the serial baud rate.
// R13: The five general flags are plain storage with no effect.
// R14: Power-up holds reset until supply is good, pin low for 100 ms.
// R15: Power-on sets the power-on flag; every other reset clears it.
// R16: Writing one to the power-on flag forces a full power-on sequence.
// R17: With monitor enabled, supply drop below threshold resets; recovery as power-on.
// R18: Monitor enable pin gates the monitor; small packages keep it always on.
// R19: Writing idle and stop together enters stop.
`timescale 1ns/100ps
module pmrc_ctrl #(
  parameter int unsigned MON_CYC = pmrc_pkg::MON_TIMEOUT_CYC, // Supply monitor timeout.
  parameter int unsigned MCD_CYC = pmrc_pkg::MCD_TIMEOUT_CYC, // Missing clock timeout.
  parameter bit SMALL_PKG = 1'b0 // Monitor always enabled.
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic supply_ok, // Supply above threshold level, async.
  input wire logic supply_monitor_enable_pin, // Monitor enable pin, async.
  input wire logic rst_pin_n_in, // Reset pin level, async, low active.
  input wire logic sfr_wr, // Register write strobe.
  input wire logic sfr_rd, // Register read strobe.
  input wire logic [7:0] sfr_addr, // Register address.
  input wire logic [7:0] sfr_wdata, // Register write data.
  input wire logic irq_pending, // Enabled interrupt pending, async.
  input wire logic wdt_enable, // Watchdog enabled.
  input wire logic wdt_expire, // Watchdog timeout, async.
  input wire logic mcd_enable, // Missing clock detector enabled.
  input wire logic [15:0] cpu_pc, // Address of next instruction.
  output logic [7:0] sfr_rdata, // Register read data.
  output logic cpu_clk_en, // CPU clock enable.
  output logic periph_clk_en, // Peripheral and oscillator enable.
  output logic cpu_reset, // Core held in reset.
  output logic [15:0] reset_vector, // Fetch address after reset.
  output logic [15:0] resume_pc, // Return address saved at idle entry.
  output logic rst_pin_n_out, // Reset pin drive value, low.
  output logic rst_pin_oe, // Reset pin drive enable.
  output logic baud_doubler // Serial baud rate doubler.
);

  pmrc_pkg::pmrc_state_e state_q;
  pmrc_pkg::pmrc_state_e state_d;

  logic [1:0] sup_sync_q;
  logic [1:0] mon_sync_q;
  logic [1:0] pin_sync_q;
  logic [1:0] irq_sync_q;
  logic [1:0] wdt_sync_q;
  logic [7:0] pwr_ctrl_q;
  logic [3:0] rst_src_q;
  logic por_active_q;
  logic force_por_q;
  logic mon_done;
  logic mcd_done;
  logic mon_on;
  logic supply_fail;
  logic pin_reset;
  logic wdt_reset;
  logic mcd_reset;
  logic pwr_wr;
  logic src_wr;
  logic any_reset;
  logic [2:0] oe_hist_q;

  // Two flip-flop synchronisers for every asynchronous input.
  always_ff @(posedge clk) begin
    if (rst) begin
      sup_sync_q <= 2'h0;
      mon_sync_q <= 2'h0;
      pin_sync_q <= 2'h3;
      irq_sync_q <= 2'h0;
      wdt_sync_q <= 2'h0;
    end else begin
      sup_sync_q <= {sup_sync_q[0], supply_ok};
      mon_sync_q <= {mon_sync_q[0], supply_monitor_enable_pin};
      pin_sync_q <= {pin_sync_q[0], rst_pin_n_in};
      irq_sync_q <= {irq_sync_q[0], irq_pending};
      wdt_sync_q <= {wdt_sync_q[0], wdt_expire};
    end
  end

  // R18: monitor enable
  assign mon_on = SMALL_PKG ? 1'b1 : mon_sync_q[1];
  // R17: supply drop reset
  assign supply_fail = mon_on && !sup_sync_q[1];

  // The pin still reads low for a few cycles after we release it, until the synchroniser catches up.
  // Without this mask every power-on release would be taken as an external pin reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_hist_q <= 3'h7;
    end else begin
      oe_hist_q <= {oe_hist_q[1:0], rst_pin_oe};
    end
  end

  assign pin_reset = !pin_sync_q[1] && !rst_pin_oe && (oe_hist_q == 3'h0);
  // R7: watchdog ends idle
  assign wdt_reset = wdt_enable && wdt_sync_q[1];
  // R10: missing clock reset
  assign mcd_reset = mcd_enable && mcd_done;
  assign pwr_wr = sfr_wr && (sfr_addr == pmrc_pkg::PWR_CTRL_ADDR);
  assign src_wr = sfr_wr && (sfr_addr == pmrc_pkg::RST_SRC_ADDR);
  assign any_reset = supply_fail || pin_reset || wdt_reset || mcd_reset || force_por_q;

  // R14: supply monitor timeout
  pmrc_timer #(
    .COUNT(MON_CYC)
  ) u_mon_timer (
    .clk(clk),
    .rst(rst),
    .restart(supply_fail || force_por_q),
    .run(por_active_q),
    .done(mon_done)
  );

  // The detector counts only while stopped, where no clock edge reaches the core.
  pmrc_timer #(
    .COUNT(MCD_CYC)
  ) u_mcd_timer (
    .clk(clk),
    .rst(rst),
    .restart(state_q != pmrc_pkg::PMRC_STOP),
    .run(1'b1),
    .done(mcd_done)
  );

  // Power-on sequence stays active until supply is good and the timeout expires.
  always_ff @(posedge clk) begin
    if (rst) begin
      por_active_q <= 1'b1;
      force_por_q <= 1'b0;
    end else begin
      // R16: forced power-on
      force_por_q <= src_wr && sfr_wdata[pmrc_pkg::POR_FLAG_BIT];
      if (supply_fail || force_por_q) begin
        por_active_q <= 1'b1;
      end else if (mon_done && sup_sync_q[1]) begin
        por_active_q <= 1'b0;
      end
    end
  end

  // Power state sequencing.
  always_comb begin
    state_d = state_q;
    case (state_q)
      pmrc_pkg::PMRC_RESET: begin
        if (!por_active_q && !any_reset) begin
          state_d = pmrc_pkg::PMRC_RUN;
        end
      end
      pmrc_pkg::PMRC_RUN: begin
        if (any_reset) begin
          state_d = pmrc_pkg::PMRC_RESET;
        // R19: stop wins
        end else if (pwr_wr && sfr_wdata[pmrc_pkg::STOP_BIT]) begin
          state_d = pmrc_pkg::PMRC_STOP;
        // R1: enter idle
        end else if (pwr_wr && sfr_wdata[pmrc_pkg::IDLE_BIT]) begin
          state_d = pmrc_pkg::PMRC_IDLE;
        end
      end
      pmrc_pkg::PMRC_IDLE: begin
        // R5: reset ends idle
        if (any_reset) begin
          state_d = pmrc_pkg::PMRC_RESET;
        // R3: interrupt wakes
        end else if (irq_sync_q[1]) begin
          state_d = pmrc_pkg::PMRC_RUN;
        end
      end
      pmrc_pkg::PMRC_STOP: begin
        // R9: only reset exits
        if (any_reset) begin
          state_d = pmrc_pkg::PMRC_RESET;
        end
      end
      default: begin
        state_d = pmrc_pkg::PMRC_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= pmrc_pkg::PMRC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Power control storage; the mode bits are never held, so they read back zero.
  always_ff @(posedge clk) begin
    if (rst || state_q == pmrc_pkg::PMRC_RESET) begin
      pwr_ctrl_q <= pmrc_pkg::PWR_CTRL_RST;
    // R13: plain flag storage
    end else if (pwr_wr) begin
      pwr_ctrl_q[pmrc_pkg::BAUD_BIT] <= sfr_wdata[pmrc_pkg::BAUD_BIT];
      pwr_ctrl_q[pmrc_pkg::FLAGS_MSB:pmrc_pkg::FLAGS_LSB] <=
        sfr_wdata[pmrc_pkg::FLAGS_MSB:pmrc_pkg::FLAGS_LSB];
    end
  end

  // Reset source flags are captured as the reset state is entered.
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_src_q <= 4'h2;
    end else if (state_q != pmrc_pkg::PMRC_RESET && state_d == pmrc_pkg::PMRC_RESET) begin
      // R15: power-on flag
      rst_src_q[pmrc_pkg::POR_FLAG_BIT] <= supply_fail || force_por_q;
      rst_src_q[pmrc_pkg::PIN_FLAG_BIT] <= pin_reset;
      rst_src_q[pmrc_pkg::MCD_FLAG_BIT] <= mcd_reset;
      rst_src_q[pmrc_pkg::WDT_FLAG_BIT] <= wdt_reset;
    end
  end

  // Read data; unmapped addresses return zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == pmrc_pkg::PWR_CTRL_ADDR) begin
      // R11: mode bits read zero
      sfr_rdata <= {pwr_ctrl_q[7:2], 2'h0};
    end else if (sfr_rd && sfr_addr == pmrc_pkg::RST_SRC_ADDR) begin
      sfr_rdata <= {4'h0, rst_src_q};
    end else if (sfr_rd) begin
      sfr_rdata <= 8'h00;
    end
  end

  // Clock gating, core reset and pin drive, all registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b1;
      cpu_reset <= 1'b1;
      rst_pin_n_out <= 1'b0;
      rst_pin_oe <= 1'b1;
      baud_doubler <= 1'b0;
      reset_vector <= pmrc_pkg::RESET_VECTOR;
    end else begin
      // R2: idle freezes core
      cpu_clk_en <= (state_d == pmrc_pkg::PMRC_RUN);
      // R8: stop halts oscillator
      periph_clk_en <= (state_d != pmrc_pkg::PMRC_STOP);
      cpu_reset <= (state_d == pmrc_pkg::PMRC_RESET);
      // R14: pin low during monitor
      rst_pin_n_out <= 1'b0;
      rst_pin_oe <= por_active_q || supply_fail;
      // R12: baud doubling
      baud_doubler <= pwr_ctrl_q[pmrc_pkg::BAUD_BIT];
      reset_vector <= pmrc_pkg::RESET_VECTOR;
    end
  end

  // R4: resume address
  always_ff @(posedge clk) begin
    if (rst) begin
      resume_pc <= 16'h0000;
    end else if (state_q == pmrc_pkg::PMRC_RUN && state_d == pmrc_pkg::PMRC_IDLE) begin
      resume_pc <= cpu_pc;
    end
  end

endmodule

// File: pmrc_ctrl_assertions.sv
// Purpose: Port checks for the power-mode and reset controller.
// Assumes: One clock domain, bound to pmrc_ctrl.
// Notes: Detector bound leaves slack for sync and state stages.
`timescale 1ns/100ps
module pmrc_chk #(
  parameter int unsigned MCD_CYC = 20 // Detector timeout.
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic sfr_wr, // Write strobe.
  input wire logic [7:0] sfr_addr, // Address.
  input wire logic [7:0] sfr_wdata, // Write data.
  input wire logic mcd_enable, // Detector on.
  input wire logic [15:0] cpu_pc, // Next address.
  input wire logic cpu_clk_en, // CPU clock.
  input wire logic periph_clk_en, // Oscillator.
  input wire logic cpu_reset, // Core reset.
  input wire logic [15:0] reset_vector, // Fetch address.
  input wire logic [15:0] resume_pc, // Return address.
  input wire logic rst_pin_n_out, // Pin value.
  input wire logic rst_pin_oe, // Pin drive.
  input wire logic baud_doubler // Doubler.
);
  logic [15:0] cnt_q;
  logic pw;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A power control write while running.
  assign pw = sfr_wr && sfr_addr == 8'h87 && cpu_clk_en && !cpu_reset;
  // Stop cycles with the detector armed; any wake clears it.
  always_ff @(posedge clk) begin
    if (rst || periph_clk_en || !mcd_enable) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  property p_idle;
    pw && sfr_wdata[1:0] == 2'h1 |=> !cpu_clk_en && periph_clk_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  property p_stop;
    pw && sfr_wdata[1] |=> !cpu_clk_en && !periph_clk_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry wrong");
  property p_resume;
    pw && sfr_wdata[1:0] == 2'h1 |=> resume_pc == $past(cpu_pc);
  endproperty
  a_resume: assert property (p_resume) else $error("resume address wrong");
  property p_baud;
    sfr_wr && sfr_addr == 8'h87 && !cpu_reset |=> ##1 baud_doubler == $past(sfr_wdata[7], 2);
  endproperty
  a_baud: assert property (p_baud) else $error("doubler wrong");
  property p_vec;
    $fell(cpu_reset) |-> cpu_clk_en && reset_vector == 16'h0000;
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_pin;
    rst_pin_oe |-> !rst_pin_n_out ##[0:1] cpu_reset;
  endproperty
  a_pin: assert property (p_pin) else $error("pin drive wrong");
  property p_wake;
    $rose(periph_clk_en) |-> ##[0:2] cpu_reset;
  endproperty
  a_wake: assert property (p_wake) else $error("stop left without reset");
  property p_mcd;
    cnt_q <= MCD_CYC + 6;
  endproperty
  a_mcd: assert property (p_mcd) else $error("detector late");
  c_idle: cover property (pw && sfr_wdata[1:0] == 2'h1);
  c_stop: cover property (pw && sfr_wdata[1]);
  c_pin: cover property ($rose(rst_pin_oe));
endmodule
bind pmrc_ctrl pmrc_chk #(.MCD_CYC(MCD_CYC)) u_chk (.clk(clk), .rst(rst), .sfr_wr(sfr_wr),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .mcd_enable(mcd_enable), .cpu_pc(cpu_pc),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .cpu_reset(cpu_reset),
  .reset_vector(reset_vector), .resume_pc(resume_pc), .rst_pin_n_out(rst_pin_n_out),
  .rst_pin_oe(rst_pin_oe), .baud_doubler(baud_doubler));

// File: pmrc_cpu_model.sv
// Purpose: CPU counter and watchdog stand-in.
// Assumes: Same clock as the controller.
// Notes: No kick input, so an enabled watchdog always expires.
`timescale 1ns/100ps
module pmrc_cpu_model #(
  parameter int unsigned WDT_CYC = 30 // Watchdog timeout.
) (
  input wire logic clk, // Clock.
  input wire logic cpu_clk_en, // CPU clock.
  input wire logic cpu_reset, // Core reset.
  input wire logic [15:0] reset_vector, // Fetch address.
  input wire logic wdt_enable, // Watchdog on.
  output logic [15:0] cpu_pc, // Next address.
  output logic wdt_expire // Timeout.
);
  int cnt;
  always_ff @(posedge clk) begin
    if (cpu_reset) begin
      cpu_pc <= reset_vector;
    end else if (cpu_clk_en) begin
      cpu_pc <= cpu_pc + 16'h0003;
    end
  end
  always_ff @(posedge clk) begin
    if (cpu_reset || !wdt_enable) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign wdt_expire = cnt >= WDT_CYC;
endmodule

// File: pmrc_ctrl_tb.sv
// Purpose: Self-checking bench for the power-mode controller.
// Assumes: Shortened supply and detector timeouts.
// Notes: Only the power-on bit of the reset source is checked.
`timescale 1ns/100ps
module pmrc_ctrl_tb;
  localparam int MON = 50;
  logic clk = 1'h0, rst = 1'h1, vdd = 1'h1, mon = 1'h1, pin_n = 1'h1;
  logic wr = 1'h0, rd = 1'h0, irq = 1'h0, wdt_en = 1'h0, mcd_en = 1'h0, wexp;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
  logic [15:0] pc, vec, rpc;
  logic cen, pen, crst, pin_o, oe, baud;
  logic [2:0] st;
  int errors = 0, samples_checked = 0, n, cyc = 0;
  logic pin_lvl;
  assign st = {oe, cen, crst};
  // The reset pin is a wired low: our own drive pulls it down, the pull-up lifts it on release.
  assign pin_lvl = pin_n && !(oe && !pin_o);
  pmrc_ctrl #(.MON_CYC(MON), .MCD_CYC(20)) uut (.clk(clk), .rst(rst), .supply_ok(vdd),
    .supply_monitor_enable_pin(mon), .rst_pin_n_in(pin_lvl), .sfr_wr(wr), .sfr_rd(rd), .sfr_addr(addr),
    .sfr_wdata(wdata), .irq_pending(irq), .wdt_enable(wdt_en), .wdt_expire(wexp), .mcd_enable(mcd_en),
    .cpu_pc(pc), .sfr_rdata(rdata), .cpu_clk_en(cen), .periph_clk_en(pen), .cpu_reset(crst),
    .reset_vector(vec), .resume_pc(rpc), .rst_pin_n_out(pin_o), .rst_pin_oe(oe), .baud_doubler(baud));
  pmrc_cpu_model u_cpu (.clk(clk), .cpu_clk_en(cen), .cpu_reset(crst), .reset_vector(vec),
    .wdt_enable(wdt_en), .cpu_pc(pc), .wdt_expire(wexp));
  // Mismatches are printed and counted at once.
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'h1; addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 r = rdata;
  endtask
  // Bounded wait on a status output; n keeps the cycles spent.
  task wt(input int k, input logic v);
    n = 0;
    while (n < 400 && st[k] !== v) begin
      @(negedge clk);
      n++;
    end
    chk(st[k], v);
  endtask
  task stop_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    wt(0, 1'h0);
    chk(n >= MON, 1'h1);
    rdr(8'hEF);
    chk(r & 8'h02, 8'h02);
    wrt(8'h87, 8'hFC);
    rdr(8'h87);
    chk(r, 8'hFC);
    chk(baud, 1'h1);
    wrt(8'h87, 8'hFD);
    rdr(8'h87);
    chk(r, 8'hFC);
    chk({cen, pen}, 2'h1);
    chk(rpc + 16'h0003, pc);
    @(posedge clk) irq <= 1'h1;
    wt(1, 1'h1);
    @(posedge clk) irq <= 1'h0;
    wrt(8'h87, 8'h03);
    @(posedge clk) irq <= 1'h1;
    repeat (8) @(negedge clk);
    chk(st, 3'h0);
    @(posedge clk) mcd_en <= 1'h1;
    wt(0, 1'h1);
    @(posedge clk) mcd_en <= 1'h0;
    irq <= 1'h0;
    wt(0, 1'h0);
    rdr(8'hEF);
    chk(r & 8'h02, 8'h00);
    rdr(8'h87);
    chk(r, 8'h00);
    @(posedge clk) wdt_en <= 1'h1;
    wrt(8'h87, 8'h01);
    wt(0, 1'h1);
    @(posedge clk) wdt_en <= 1'h0;
    wt(0, 1'h0);
    wrt(8'hEF, 8'h02);
    wt(2, 1'h1);
    wt(0, 1'h0);
    chk(n >= MON, 1'h1);
    rdr(8'hEF);
    chk(r & 8'h02, 8'h02);
    @(posedge clk) vdd <= 1'h0;
    wt(2, 1'h1);
    @(posedge clk) vdd <= 1'h1;
    wt(0, 1'h0);
    chk(n >= MON, 1'h1);
    @(posedge clk) mon <= 1'h0;
    vdd <= 1'h0;
    repeat (20) @(negedge clk);
    chk(crst, 1'h0);
    @(posedge clk) vdd <= 1'h1;
    mon <= 1'h1;
    repeat (5) @(posedge clk);
    pin_n <= 1'h0;
    wt(0, 1'h1);
    @(posedge clk) pin_n <= 1'h1;
    wt(0, 1'h0);
    rdr(8'hEF);
    chk(r & 8'h02, 8'h00);
    stop_test();
  end
endmodule
